/* File: adc_acq_pkg.sv */
// Purpose: shared constants and types for the acquisition control block
// Assumes: 20 MHz system clock, plain register port, 16-bit data
// Notes: register offsets are word indices on the plain port
`default_nettype none
package adc_acq_pkg;
  // ==========================================
  // register map
  localparam logic [2:0] REG_CONTROL = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_INTERVAL = 3'h2;
  localparam logic [2:0] REG_FIFO_DATA = 3'h3;
  localparam logic [2:0] REG_CLEAR = 3'h4;
  // control fields
  localparam int CTL_CHAN_LSB = 0;
  localparam int CTL_SCAN_BIT = 4;
  localparam int CTL_TIMER_EN_BIT = 5;
  localparam int CTL_EXT_EN_BIT = 6;
  // status fields
  localparam int STS_PRESENT_BIT = 0;
  localparam int STS_OVERFLOW_BIT = 1;
  localparam int STS_BUSY_BIT = 2;
  localparam int STS_CHAN_LSB = 4;
  // clear register fields
  localparam int CLR_OVERFLOW_BIT = 0;
  localparam int CLR_REINIT_BIT = 1;
  // reset values
  localparam logic [15:0] INTERVAL_RESET = 16'h0002;
  localparam logic [2:0] CHAN_RESET = 3'h0;
  // timing
  localparam int SYS_CLK_HZ = 20000000;
  localparam int TIMEBASE_HZ = 1000000;
  localparam int TICK_CYCLES = SYS_CLK_HZ / TIMEBASE_HZ;
  localparam int INTERVAL_MIN_US = 2;
  localparam int EXT_LATENCY_US = 20;
  localparam int EXT_LATENCY_CYCLES = EXT_LATENCY_US * (SYS_CLK_HZ / 1000000);
  localparam int CONV_CYCLES_DEFAULT = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int RAW_WIDTH = 12;
  localparam int WORD_WIDTH = 16;

  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic [15:0] data;
  } sample_t;
endpackage
`default_nettype wire

/* File: adc_skid_buf.sv */
// Purpose: two-entry valid/ready buffer in the sample path
// Assumes: single clock, async active-low reset
// Notes: input ready stays high while a slot is free
`timescale 1ns/10ps
`default_nettype none
module adc_skid_buf #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  typedef struct packed {
    logic [1:0] cnt;
    logic [WIDTH-1:0] d0;
    logic [WIDTH-1:0] d1;
  } buf_state_t;
  buf_state_t st;
  buf_state_t next_st;
  logic push;
  logic pop;
  // ==========================================
  // next state
  always_comb begin
    next_st = st;
    push = in_valid_i && (st.cnt != 2'd2);
    pop = out_ready_i && (st.cnt != 2'd0);
    if (pop) begin
      next_st.d0 = st.d1;
    end
    if (push) begin
      if ((st.cnt == 2'd0) || (st.cnt == 2'd1 && pop)) begin
        next_st.d0 = in_data_i;
      end else begin
        next_st.d1 = in_data_i;
      end
    end
    next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign in_ready_o = (st.cnt != 2'd2);
  assign out_valid_o = (st.cnt != 2'd0);
  assign out_data_o = st.d0;
endmodule
`default_nettype wire

/* File: adc_acq_ctrl.sv */
// Purpose: sample timer, trigger, channel mux control and result fifo
// Assumes: converter interface is start pulse, done pulse, 12-bit result
// Notes: plain register port, read data one cycle after read strobe
`timescale 1ns/10ps
`default_nettype none
module adc_acq_ctrl
  import adc_acq_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int CONV_CYCLES = CONV_CYCLES_DEFAULT
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic external_convert_strobe_i,
  output logic [2:0] mux_sel_o,
  output logic conv_start_o,
  input wire logic conv_done_i,
  input wire logic [RAW_WIDTH-1:0] conv_result_i,
  output logic sample_timer_output_o,
  output logic data_present_o,
  output logic overflow_o
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [2:0] chan_top;
    logic scan;
    logic timer_en;
    logic ext_en;
    logic [15:0] interval;
    logic [15:0] tcount;
    logic [4:0] tick;
    logic timer_out;
    logic timer_out_d;
    logic ext_s1;
    logic ext_s2;
    logic ext_d;
    logic busy;
    logic pend;
    logic [2:0] chan;
    logic [2:0] conv_chan;
    logic start;
    logic [PW-1:0] rd_ptr;
    logic [PW-1:0] wr_ptr;
    logic [PW:0] count;
    logic overflow;
    logic [15:0] rdata;
  } ctrl_state_t;

  ctrl_state_t st;
  ctrl_state_t next_st;
  logic [15:0] mem [DEPTH];
  logic buf_in_ready;
  logic buf_out_valid;
  logic [15:0] buf_out_data;
  logic [15:0] ext_word;
  logic fifo_push;
  logic fifo_full;
  logic fifo_pop;
  logic trig;
  logic wr_ctl;

  // ==========================================
  // result capture
  assign ext_word = {{(WORD_WIDTH - RAW_WIDTH){conv_result_i[RAW_WIDTH-1]}},
                     conv_result_i};

  adc_skid_buf #(
    .WIDTH(WORD_WIDTH)
  ) u_buf (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(conv_done_i),
    .in_ready_o(buf_in_ready),
    .in_data_i(ext_word),
    .out_valid_o(buf_out_valid),
    .out_ready_i(1'b1),
    .out_data_o(buf_out_data)
  );

  assign fifo_full = (st.count == DEPTH[PW:0]);
  assign fifo_pop = reg_rd_i && (reg_addr_i == REG_FIFO_DATA) && (st.count != '0);
  assign fifo_push = buf_out_valid && (!fifo_full || fifo_pop);
  assign wr_ctl = reg_wr_i && (reg_addr_i == REG_CONTROL);

  // ==========================================
  // next state
  always_comb begin
    next_st = st;
    next_st.start = 1'b0;
    // sample-interval timer: 1 us tick, down count, reload at one
    next_st.timer_out_d = st.timer_out;
    if (st.tick == 5'(TICK_CYCLES - 1)) begin
      next_st.tick = '0;
    end else begin
      next_st.tick = st.tick + 5'd1;
    end
    if (st.timer_en && st.tick == 5'(TICK_CYCLES - 1)) begin
      if (st.tcount <= 16'd1) begin
        next_st.tcount = st.interval;
        next_st.timer_out = 1'b1;
      end else begin
        next_st.tcount = st.tcount - 16'd1;
        next_st.timer_out = 1'b0;
      end
    end
    // external strobe synchroniser and edge
    next_st.ext_s1 = external_convert_strobe_i;
    next_st.ext_s2 = st.ext_s1;
    next_st.ext_d = st.ext_s2;
    trig = (st.timer_out && !st.timer_out_d) ||
           (st.ext_en && st.ext_s2 && !st.ext_d);
    if (trig) begin
      next_st.pend = 1'b1;
    end
    // conversion launch; converter is free once its result is handed off
    if (conv_done_i && buf_in_ready) begin
      next_st.busy = 1'b0;
      if (st.scan) begin
        next_st.chan = (st.chan == 3'd0) ? st.chan_top : st.chan - 3'd1;
      end
    end
    if ((st.pend || trig) && !st.busy) begin
      next_st.start = 1'b1;
      next_st.busy = 1'b1;
      next_st.pend = 1'b0;
      next_st.conv_chan = st.chan;
    end
    // fifo pointers
    if (fifo_push) begin
      next_st.wr_ptr = st.wr_ptr + PW'(1);
    end
    if (fifo_pop) begin
      next_st.rd_ptr = st.rd_ptr + PW'(1);
    end
    next_st.count = st.count + (PW + 1)'(fifo_push) - (PW + 1)'(fifo_pop);
    if (buf_out_valid && fifo_full && !fifo_pop) begin
      next_st.overflow = 1'b1;
    end else if (reg_wr_i && reg_addr_i == REG_CLEAR &&
                 (reg_wdata_i[CLR_OVERFLOW_BIT] || reg_wdata_i[CLR_REINIT_BIT])) begin
      next_st.overflow = 1'b0;
    end
    // register writes
    if (wr_ctl) begin
      next_st.chan_top = reg_wdata_i[CTL_CHAN_LSB +: 3];
      next_st.chan = reg_wdata_i[CTL_CHAN_LSB +: 3];
      next_st.scan = reg_wdata_i[CTL_SCAN_BIT];
      next_st.timer_en = reg_wdata_i[CTL_TIMER_EN_BIT];
      next_st.ext_en = reg_wdata_i[CTL_EXT_EN_BIT];
    end
    if (reg_wr_i && reg_addr_i == REG_INTERVAL) begin
      if (reg_wdata_i < 16'(INTERVAL_MIN_US)) begin
        next_st.interval = 16'(INTERVAL_MIN_US);
      end else begin
        next_st.interval = reg_wdata_i;
      end
      next_st.tcount = next_st.interval;
    end
    if (reg_wr_i && reg_addr_i == REG_CLEAR && reg_wdata_i[CLR_REINIT_BIT]) begin
      next_st.rd_ptr = '0;
      next_st.wr_ptr = '0;
      next_st.count = '0;
      next_st.pend = 1'b0;
      next_st.tcount = st.interval;
      next_st.chan = st.chan_top;
    end
    // register reads
    next_st.rdata = '0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        REG_CONTROL: begin
          next_st.rdata[CTL_CHAN_LSB +: 3] = st.chan_top;
          next_st.rdata[CTL_SCAN_BIT] = st.scan;
          next_st.rdata[CTL_TIMER_EN_BIT] = st.timer_en;
          next_st.rdata[CTL_EXT_EN_BIT] = st.ext_en;
        end
        REG_STATUS: begin
          next_st.rdata[STS_PRESENT_BIT] = (st.count != '0);
          next_st.rdata[STS_OVERFLOW_BIT] = st.overflow;
          next_st.rdata[STS_BUSY_BIT] = st.busy;
          next_st.rdata[STS_CHAN_LSB +: 3] = st.chan;
        end
        REG_INTERVAL: begin
          next_st.rdata = st.interval;
        end
        REG_FIFO_DATA: begin
          next_st.rdata = (st.count != '0) ? mem[st.rd_ptr] : 16'h0000;
        end
        default: begin
          next_st.rdata = 16'h0000;
        end
      endcase
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
      st.interval <= INTERVAL_RESET;
      st.tcount <= INTERVAL_RESET;
      st.chan <= CHAN_RESET;
      st.chan_top <= CHAN_RESET;
    end else begin
      st <= next_st;
    end
  end

  // fifo storage, one word per entry
  always_ff @(posedge sys_clk_i) begin
    if (fifo_push) begin
      mem[st.wr_ptr] <= buf_out_data;
    end
  end

  // ==========================================
  // outputs
  assign reg_rdata_o = st.rdata;
  assign mux_sel_o = st.conv_chan;
  assign conv_start_o = st.start;
  assign sample_timer_output_o = st.timer_out;
  assign data_present_o = (st.count != '0);
  assign overflow_o = st.overflow;
endmodule
`default_nettype wire

/* File: adc_acq_props.sv */
// Purpose: port checks for the acquisition control block
// Assumes: control fields as declared in adc_acq_pkg
// Notes: mode bits are shadowed from register writes
`timescale 1ns/10ps
`default_nettype none
module adc_acq_props
  import adc_acq_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic external_convert_strobe_i,
  input wire logic [2:0] mux_sel_o,
  input wire logic conv_start_o,
  input wire logic conv_done_i,
  input wire logic sample_timer_output_o,
  input wire logic data_present_o,
  input wire logic overflow_o
);
  // ==========================================
  // shadow of mode and scan history
  localparam int C_LAT = 400;
  logic scan_q, ext_q, seen;
  logic [2:0] top, last;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {scan_q, ext_q, seen, top, last} <= '0;
    end else begin
      if (reg_wr_i && reg_addr_i == REG_CONTROL) begin
        scan_q <= reg_wdata_i[CTL_SCAN_BIT];
        ext_q <= reg_wdata_i[CTL_EXT_EN_BIT];
        top <= reg_wdata_i[2:0];
      end
      if (reg_wr_i) seen <= 1'b0;
      else if (conv_start_o) seen <= 1'b1;
      if (conv_start_o) last <= mux_sel_o;
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  sequence s_tick_high;
    sample_timer_output_o [*8] ##12 sample_timer_output_o;
  endsequence
  property p_present;
    conv_done_i |-> ##[1:4] data_present_o;
  endproperty
  a_present: assert property (p_present) else $error("result not queued");
  property p_timer;
    $rose(sample_timer_output_o) |-> ##[1:40] conv_start_o;
  endproperty
  a_timer: assert property (p_timer) else $error("timer edge gave no start");
  property p_ext;
    ext_q && $rose(external_convert_strobe_i) |-> ##[1:C_LAT] conv_start_o;
  endproperty
  a_ext: assert property (p_ext) else $error("external edge gave no start");
  property p_single;
    !scan_q && conv_start_o && !$past(reg_wr_i) |-> mux_sel_o == top;
  endproperty
  a_single: assert property (p_single) else $error("channel moved in single mode");
  property p_step;
    scan_q && seen && conv_start_o |-> mux_sel_o == (last == 3'h0 ? top : last - 3'h1);
  endproperty
  a_step: assert property (p_step) else $error("scan step wrong");
  property p_range;
    scan_q && seen |-> mux_sel_o <= top;
  endproperty
  a_range: assert property (p_range) else $error("scan above top channel");
  property p_sticky;
    overflow_o && !(reg_wr_i && reg_addr_i == REG_CLEAR) |=> overflow_o;
  endproperty
  a_sticky: assert property (p_sticky) else $error("overflow dropped alone");
  property p_width;
    $rose(sample_timer_output_o) |-> s_tick_high ##1 !sample_timer_output_o;
  endproperty
  a_width: assert property (p_width) else $error("timer pulse width wrong");
endmodule
bind adc_acq_ctrl adc_acq_props u_props (.sys_clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .external_convert_strobe_i, .mux_sel_o, .conv_start_o, .conv_done_i,
  .sample_timer_output_o, .data_present_o, .overflow_o);
`default_nettype wire

/* File: adc_conv_model.sv */
// Purpose: converter model, answers each start with one result
// Assumes: one start outstanding at a time
// Notes: result lines toggle while no result is offered
`timescale 1ns/10ps
`default_nettype none
module adc_conv_model
  import adc_acq_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic slow_i,
  input wire logic [RAW_WIDTH-1:0] base_i,
  input wire logic start_i,
  input wire logic [2:0] chan_i,
  output logic done_o,
  output logic [RAW_WIDTH-1:0] result_o
);
  int unsigned cnt;
  logic [2:0] chan;
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= 0;
      chan <= 3'h0;
      done_o <= 1'b0;
      result_o <= '0;
    end else begin
      done_o <= 1'b0;
      result_o <= ~result_o;
      if (start_i) begin
        cnt <= slow_i ? 12 : 3;
        chan <= chan_i;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
        if (cnt == 1) begin
          done_o <= 1'b1;
          result_o <= base_i ^ {9'h000, chan};
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb.sv */
// Purpose: self-checking bench for the acquisition control block
// Assumes: 20 MHz clock, converter model on the far side
// Notes: table rows cover each channel in single mode
`timescale 1ns/10ps
`default_nettype none
module tb;
  import adc_acq_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ext = 1'b0;
  logic slow = 1'b0;
  logic [11:0] base = 12'h000;
  logic [15:0] rdata, got;
  logic [2:0] mux;
  logic start, done, tmr, present, ovf;
  logic [11:0] res;
  int errors = 0;
  int checks_done = 0;
  int i;
  time t0;
  logic [30:0] rows [8] = '{{3'h0, 12'h800, 16'hf800}, {3'h1, 12'h7fe, 16'h07ff},
    {3'h2, 12'h000, 16'h0002}, {3'h3, 12'hffc, 16'hffff}, {3'h4, 12'h800, 16'hf804},
    {3'h5, 12'h7f0, 16'h07f5}, {3'h6, 12'ha00, 16'hfa06}, {3'h7, 12'h123, 16'h0124}};
  always #25 clk = ~clk;
  adc_acq_ctrl dut (.sys_clk_i(clk), .arst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .external_convert_strobe_i(ext),
    .mux_sel_o(mux), .conv_start_o(start), .conv_done_i(done), .conv_result_i(res),
    .sample_timer_output_o(tmr), .data_present_o(present), .overflow_o(ovf));
  adc_conv_model u_conv (.sys_clk_i(clk), .arst_n_i(rst_n), .slow_i(slow), .base_i(base),
    .start_i(start), .chan_i(mux), .done_o(done), .result_o(res));
  // ==========================================
  // tasks
  function automatic logic [15:0] sx(input logic [11:0] r);
    return {{4{r[11]}}, r};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    while (k < 400 && done !== 1'b1) begin
      @(posedge clk);
      #1 k++;
    end
    if (k == 400) begin
      errors++;
      $display("[ERR] %0t no conversion result", $time);
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic fire();
    @(posedge clk);
    ext <= 1'b1;
    repeat (3) @(posedge clk);
    ext <= 1'b0;
    wait_done();
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk({11'h000, mux, present, ovf}, 16'h0000);
    rd_reg(3'h5, got);
    chk(got, 16'h0000);
    rd_reg(REG_INTERVAL, got);
    chk(got, INTERVAL_RESET);
    foreach (rows[n]) begin
      base <= rows[n][27:16];
      wr_reg(REG_CONTROL, 16'h0040 | 16'(rows[n][30:28]));
      fire();
      chk({13'h0000, mux}, 16'(rows[n][30:28]));
      rd_reg(REG_FIFO_DATA, got);
      chk(got, rows[n][15:0]);
      chk({15'h0000, present}, 16'h0000);
    end
    slow <= 1'b1;
    wr_reg(REG_CONTROL, 16'h0043);
    rd_reg(REG_CONTROL, got);
    chk(got, 16'h0043);
    rd_reg(REG_STATUS, got);
    chk(got & 16'h0070, 16'h0030);
    for (i = 0; i < 17; i++) begin
      base <= 12'(i);
      fire();
    end
    rd_reg(REG_STATUS, got);
    chk(got & 16'h0003, 16'h0003);
    for (i = 0; i < 16; i++) begin
      rd_reg(REG_FIFO_DATA, got);
      chk(got, sx(12'(i) ^ 12'h003));
    end
    chk({14'h0000, present, ovf}, 16'h0001);
    wr_reg(REG_CLEAR, 16'h0001);
    #1 chk({15'h0000, ovf}, 16'h0000);
    slow <= 1'b0;
    base <= 12'h100;
    wr_reg(REG_INTERVAL, 16'h0000);
    rd_reg(REG_INTERVAL, got);
    chk(got, 16'(INTERVAL_MIN_US));
    wr_reg(REG_CONTROL, 16'h0032);
    for (i = 0; i < 4; i++) wait_done();
    @(posedge tmr);
    t0 = $time;
    @(posedge tmr);
    chk(16'(($time - t0) / 50), 16'h0028);
    repeat (25) @(posedge clk);
    wr_reg(REG_CONTROL, 16'h0000);
    for (i = 0; i < 4; i++) begin
      rd_reg(REG_FIFO_DATA, got);
      chk(got, sx(12'h100 ^ 12'((5 - i) % 3)));
    end
    repeat (20) @(posedge clk);
    wr_reg(REG_CLEAR, 16'h0002);
    #1 chk({14'h0000, present, ovf}, 16'h0000);
    summarize();
  end
endmodule
`default_nettype wire
